// [pkg/pic_pkg.sv]
// Constants, register map and state layout of the priority interrupt block
package pic_pkg;

    // Register byte addresses
    localparam logic [31:0] PIC_OFF_PRI00   = 32'hFE08_0000;
    localparam logic [31:0] PIC_OFF_PEND00  = 32'hFE08_0020;
    localparam logic [31:0] PIC_OFF_MASK00  = 32'hFE08_0040;
    localparam logic [31:0] PIC_OFF_MCLR00  = 32'hFE08_0060;
    localparam logic [31:0] PIC_OFF_ICTRL   = 32'hFFD0_0000;
    localparam logic [31:0] PIC_OFF_PRI_A   = 32'hFFD0_0004;
    localparam logic [31:0] PIC_OFF_PRI_B   = 32'hFFD0_0008;
    localparam logic [31:0] PIC_OFF_PRI_C   = 32'hFFD0_000C;
    localparam logic [31:0] PIC_OFF_PRI_D   = 32'hFFD0_0010;
    localparam logic [31:0] PIC_OFF_EVT     = 32'hFFD0_0028;

    // Reset values
    localparam logic [15:0] PIC_RST_PRI_ABC = 16'h0000;
    localparam logic [15:0] PIC_RST_PRI_D   = 16'hDA74;
    localparam logic [31:0] PIC_RST_PRI00   = 32'h0000_0000;
    localparam logic [9:0]  PIC_RST_MASK00  = 10'h3FF;

    // Interrupt control field positions
    localparam int PIC_ICTRL_PIN_LVL  = 15;
    localparam int PIC_ICTRL_NMI_HOLD = 9;
    localparam int PIC_ICTRL_EDGE     = 8;
    localparam int PIC_ICTRL_INDEP    = 7;

    // Levels, counts and codes
    localparam logic [4:0]  PIC_NMI_LEVEL     = 5'h10;
    localparam logic [2:0]  PIC_NMI_BLIND_CYC = 3'h6;
    localparam logic [3:0]  PIC_IRL_IDLE      = 4'hF;
    localparam int          PIC_MAX_PER       = 20;
    localparam int          PIC_ABC_SRCS      = 12;
    localparam logic [11:0] PIC_CODE_NONE     = 12'h000;
    localparam logic [11:0] PIC_CODE_NMI      = 12'h1C0;
    localparam logic [11:0] PIC_CODE_IRL_BASE = 12'h200;
    localparam logic [11:0] PIC_CODE_PER_BASE = 12'h400;
    localparam logic [11:0] PIC_CODE_IRL_IND [4] =
        '{12'h240, 12'h2A0, 12'h300, 12'h360};

    typedef struct packed {
        logic        nmi_hold;
        logic        edge_sel;
        logic        indep;
        logic [15:0] pri_a;
        logic [15:0] pri_b;
        logic [15:0] pri_c;
        logic [15:0] pri_d;
        logic [31:0] pri00;
        logic [9:0]  mask00;
        logic        nmi_smp;
        logic        nmi_pend;
        logic [2:0]  blind;
        logic [3:0]  irl_s0;
        logic [3:0]  irl_s1;
        logic [3:0]  irl_filt;
        logic        req;
        logic [4:0]  level;
        logic [11:0] code;
        logic [11:0] evt;
        logic [31:0] rdata;
    } pic_state_type;

    localparam pic_state_type PIC_RST_STATE = '{
        nmi_hold: 1'b0, edge_sel: 1'b0, indep: 1'b0,
        pri_a: PIC_RST_PRI_ABC, pri_b: PIC_RST_PRI_ABC,
        pri_c: PIC_RST_PRI_ABC, pri_d: PIC_RST_PRI_D,
        pri00: PIC_RST_PRI00, mask00: PIC_RST_MASK00,
        nmi_smp: 1'b0, nmi_pend: 1'b0, blind: 3'h0,
        irl_s0: PIC_IRL_IDLE, irl_s1: PIC_IRL_IDLE,
        irl_filt: PIC_IRL_IDLE, req: 1'b0, level: 5'h00,
        code: PIC_CODE_NONE, evt: PIC_CODE_NONE, rdata: 32'h0000_0000};

endpackage : pic_pkg

// [design/pic_top.sv]
// Priority interrupt controller: pins, peripheral lines, registers, CPU side
//
// Summary of operation
// - Levels 16 to 1 rank; zero ignored
// - Non-maskable is level 16, taken unless held
// - Sleep or standby accepts non-maskable despite hold
// - Control bit lets non-maskable pass hold
// - Non-maskable pin edge polarity is selectable
// - Polarity change blinds detection six cycles
// - Acceptance never alters CPU threshold field
// - Inverted four lines give level, 1111 idle
// - Three identical samples before new level
// - Standby filtering runs on timekeeper tick
// - Encoded lines masked by CPU threshold
// - Control bit makes four independent requests
// - Peripheral priorities 15 to 0 programmable
// - Event code names the accepted source
// - Vanished request at acceptance gives code zero
// - Control register resets to pin level in bit 15
// - Readable bit shows non-maskable pin level
// - Equal levels resolved by fixed order
`timescale 1ns/1ps

module pic_top
    import pic_pkg::*;
#(
    parameter int NPER = PIC_MAX_PER
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // Register port
    input  wire logic [31:0]       reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // Request pins
    input  wire logic              nmi_pin,
    input  wire logic [3:0]        irl_n,
    input  wire logic              rtc_tick,
    // Peripheral request lines
    input  wire logic [NPER-1:0]   periph_req,
    // CPU side
    input  wire logic              cpu_hold,
    input  wire logic [3:0]        cpu_threshold,
    input  wire logic              sleep_mode,
    input  wire logic              standby_mode,
    input  wire logic              int_ack,
    output logic                   int_req,
    output logic [4:0]             int_level,
    output logic [11:0]            int_code
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check

    if (NPER < 1 || NPER > PIC_MAX_PER) begin : g_chk
        $error("NPER must be 1 to 20");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] nib(input logic [79:0] tbl,
                                       input int idx);
        return tbl[idx*4 +: 4];
    endfunction : nib

    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] off);
        return a == off;
    endfunction : hit

    pic_state_type s_q;
    pic_state_type s_d;

    logic          nmi_edge;
    logic          nmi_ok;
    logic          smp_en;
    logic [79:0]   pri_tbl;
    logic [19:0]   per_v;
    logic [19:0]   per_m;
    logic [4:0]    best_lv;
    logic [11:0]   best_code;
    logic [4:0]    cand;
    logic [15:0]   ictrl_rd;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;

        // Pin is synchronous; one flop gives the previous level
        s_d.nmi_smp = nmi_pin;
        nmi_edge = s_q.edge_sel ? (nmi_pin & ~s_q.nmi_smp)
                                : (~nmi_pin & s_q.nmi_smp);
        if (s_q.blind != 3'h0) begin
            s_d.blind = s_q.blind - 3'h1;
        end
        if (int_ack && s_q.req && s_q.code == PIC_CODE_NMI) begin
            s_d.nmi_pend = 1'b0;
        end
        // Set after clear so an edge in the clearing cycle is not lost
        if (nmi_edge && s_q.blind == 3'h0) begin
            s_d.nmi_pend = 1'b1;
        end

        // Filter ticks on the timekeeper while the bus clock is off
        smp_en = ~standby_mode | rtc_tick;
        if (smp_en) begin
            s_d.irl_s0 = irl_n;
            s_d.irl_s1 = s_q.irl_s0;
            if (irl_n == s_q.irl_s0 && s_q.irl_s0 == s_q.irl_s1) begin
                s_d.irl_filt = irl_n;
            end
        end

        // Arbitration, strict compare keeps earlier source on ties
        pri_tbl = {s_q.pri00, s_q.pri_c, s_q.pri_b, s_q.pri_a};
        per_v = '0;
        per_v[NPER-1:0] = periph_req;
        per_m = per_v & ~{s_q.mask00[7:0], 12'h000};
        best_lv = 5'h00;
        best_code = PIC_CODE_NONE;
        nmi_ok = s_q.nmi_pend
               && (!cpu_hold || s_q.nmi_hold
                   || sleep_mode || standby_mode);
        if (nmi_ok) begin
            best_lv = PIC_NMI_LEVEL;
            best_code = PIC_CODE_NMI;
        end else begin
            if (!s_q.indep) begin
                cand = {1'b0, ~s_q.irl_filt};
                if (cand > best_lv) begin
                    best_lv = cand;
                    // Code steps by line pattern, not by level
                    best_code = PIC_CODE_IRL_BASE
                              + {3'h0, s_q.irl_filt, 5'h00};
                end
            end else begin
                for (int k = 0; k < 4; k++) begin
                    cand = {1'b0, s_q.pri_d[(3-k)*4 +: 4]};
                    if (!s_q.irl_filt[k] && cand > best_lv) begin
                        best_lv = cand;
                        best_code = PIC_CODE_IRL_IND[k];
                    end
                end
            end
            for (int i = 0; i < NPER; i++) begin
                cand = {1'b0, nib(pri_tbl, i)};
                // Level zero never beats the empty start
                if (per_m[i] && cand > best_lv) begin
                    best_lv = cand;
                    best_code = PIC_CODE_PER_BASE + 12'(i * 32);
                end
            end
        end

        // Threshold is only read here, never written back
        s_d.req = nmi_ok || (!cpu_hold
                  && best_lv > {1'b0, cpu_threshold});
        s_d.level = s_d.req ? best_lv : 5'h00;
        s_d.code = s_d.req ? best_code : PIC_CODE_NONE;

        // Request gone by acceptance leaves a zero code
        if (int_ack) begin
            s_d.evt = s_q.req ? s_q.code : PIC_CODE_NONE;
        end

        // Register writes
        if (reg_wr) begin
            if (hit(reg_addr, PIC_OFF_ICTRL)) begin
                s_d.nmi_hold = reg_wdata[PIC_ICTRL_NMI_HOLD];
                s_d.edge_sel = reg_wdata[PIC_ICTRL_EDGE];
                s_d.indep = reg_wdata[PIC_ICTRL_INDEP];
                if (reg_wdata[PIC_ICTRL_EDGE] != s_q.edge_sel) begin
                    s_d.blind = PIC_NMI_BLIND_CYC;
                end
            end
            if (hit(reg_addr, PIC_OFF_PRI_A)) begin
                s_d.pri_a = reg_wdata[15:0];
            end
            if (hit(reg_addr, PIC_OFF_PRI_B)) begin
                s_d.pri_b = reg_wdata[15:0];
            end
            if (hit(reg_addr, PIC_OFF_PRI_C)) begin
                s_d.pri_c = reg_wdata[15:0];
            end
            if (hit(reg_addr, PIC_OFF_PRI_D)) begin
                s_d.pri_d = reg_wdata[15:0];
            end
            if (hit(reg_addr, PIC_OFF_PRI00)) begin
                s_d.pri00 = reg_wdata;
            end
            // Ones set mask bits here and clear them below
            if (hit(reg_addr, PIC_OFF_MASK00)) begin
                s_d.mask00 = s_q.mask00 | reg_wdata[9:0];
            end
            if (hit(reg_addr, PIC_OFF_MCLR00)) begin
                s_d.mask00 = s_q.mask00 & ~reg_wdata[9:0];
            end
        end

        // Read data stands one cycle only; unmapped reads give zero
        ictrl_rd = 16'h0000;
        ictrl_rd[PIC_ICTRL_PIN_LVL] = s_q.nmi_smp;
        ictrl_rd[PIC_ICTRL_NMI_HOLD] = s_q.nmi_hold;
        ictrl_rd[PIC_ICTRL_EDGE] = s_q.edge_sel;
        ictrl_rd[PIC_ICTRL_INDEP] = s_q.indep;
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (1'b1)
                hit(reg_addr, PIC_OFF_ICTRL):
                    s_d.rdata = {16'h0000, ictrl_rd};
                hit(reg_addr, PIC_OFF_PRI_A):
                    s_d.rdata = {16'h0000, s_q.pri_a};
                hit(reg_addr, PIC_OFF_PRI_B):
                    s_d.rdata = {16'h0000, s_q.pri_b};
                hit(reg_addr, PIC_OFF_PRI_C):
                    s_d.rdata = {16'h0000, s_q.pri_c};
                hit(reg_addr, PIC_OFF_PRI_D):
                    s_d.rdata = {16'h0000, s_q.pri_d};
                hit(reg_addr, PIC_OFF_PRI00):
                    s_d.rdata = s_q.pri00;
                hit(reg_addr, PIC_OFF_PEND00):
                    s_d.rdata = {24'h00_0000, per_v[19:12]};
                hit(reg_addr, PIC_OFF_MASK00):
                    s_d.rdata = {22'h00_0000, s_q.mask00};
                hit(reg_addr, PIC_OFF_EVT):
                    s_d.rdata = {20'h0_0000, s_q.evt};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= PIC_RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign int_req   = s_q.req;
    assign int_level = s_q.level;
    assign int_code  = s_q.code;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_ZERO_IGNORED: assert property (
        int_req |-> int_level != 5'h00)
        else $error("Request presented at level zero");

    AST_NMI_TOP: assert property (
        int_req && int_code == PIC_CODE_NMI |-> int_level == PIC_NMI_LEVEL)
        else $error("Non-maskable not at level 16");

    AST_SLEEP_NMI: assert property (
        s_q.nmi_pend && !int_ack && (sleep_mode || standby_mode)
        |=> int_req && int_code == PIC_CODE_NMI)
        else $error("Non-maskable not presented in low power");

    AST_HOLD_MASK: assert property (
        cpu_hold && !s_q.nmi_hold && !sleep_mode && !standby_mode
        |=> !int_req)
        else $error("Request presented while held");

    AST_EDGE_SEEN: assert property (
        s_q.blind == 3'h0 && s_q.edge_sel && !s_q.nmi_smp && nmi_pin
        |=> s_q.nmi_pend)
        else $error("Rising edge missed");

    AST_BLIND: assert property (
        reg_wr && hit(reg_addr, PIC_OFF_ICTRL)
        && reg_wdata[PIC_ICTRL_EDGE] != s_q.edge_sel && !s_q.nmi_pend
        && !nmi_pin && !s_q.nmi_smp
        |=> !s_q.nmi_pend [*6])
        else $error("Edge taken inside blind window");

    AST_FILTER: assert property (
        $changed(s_q.irl_filt)
        |-> $past(s_q.irl_s0) == s_q.irl_filt
            && $past(s_q.irl_s1) == s_q.irl_filt)
        else $error("Line level taken before three samples");

    AST_THRESH: assert property (
        int_req && int_code != PIC_CODE_NMI
        |-> int_level > {1'b0, $past(cpu_threshold)})
        else $error("Request at or below threshold");

    AST_EVENT: assert property (
        int_ack |=> s_q.evt == ($past(int_req) ? $past(int_code)
                                               : PIC_CODE_NONE))
        else $error("Event code wrong after acceptance");

    AST_PIN_READ: assert property (
        reg_rd && hit(reg_addr, PIC_OFF_ICTRL)
        |=> reg_rdata[PIC_ICTRL_PIN_LVL] == $past(s_q.nmi_smp))
        else $error("Pin level bit wrong");

    AST_IRL_IDLE: assert property (
        !s_q.nmi_pend && !s_q.indep && s_q.irl_filt == PIC_IRL_IDLE
        && periph_req == '0 |=> !int_req)
        else $error("Request with idle lines");

    AST_STBY_FREEZE: assert property (
        standby_mode && !rtc_tick |=> $stable(s_q.irl_filt))
        else $error("Line filter moved without timekeeper tick");

    AST_INDEP_LVL: assert property (
        int_req && $past(s_q.indep) && int_code == PIC_CODE_IRL_IND[0]
        |-> int_level == {1'b0, $past(s_q.pri_d[15:12])})
        else $error("Independent line at wrong level");

    AST_NMI_CLEAR: assert property (
        int_ack && int_req && int_code == PIC_CODE_NMI && !nmi_edge
        |=> !s_q.nmi_pend)
        else $error("Non-maskable pending after acceptance");

    COV_NMI_ACK: cover property (
        int_req && int_code == PIC_CODE_NMI ##1 int_ack);
    COV_IRL_REQ: cover property (
        int_req && int_code >= PIC_CODE_IRL_BASE
        && int_code < PIC_CODE_PER_BASE);
    COV_PER_REQ: cover property (
        int_req && int_code >= PIC_CODE_PER_BASE);
    COV_SPURIOUS: cover property (!int_req && int_ack);
    COV_STBY_IRL: cover property (
        standby_mode && int_req && int_code == PIC_CODE_IRL_BASE);

endmodule : pic_top

// [verif/pic_cpu_model.sv]
// CPU core model that accepts requests presented by the controller
`timescale 1ns/1ps

module pic_cpu_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Request from controller
    input  wire logic       int_req,
    input  wire logic [4:0] int_level,
    // Core state
    input  wire logic [3:0] cpu_threshold,
    input  wire logic       accept_en,
    // Acceptance pulse
    output logic            int_ack
);
    logic [1:0] gap_q;

    ////////////////////////////////////////////////////////////////////////
    // Gap after each ack: the request only falls two edges later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            int_ack <= 1'b0;
            gap_q   <= 2'h0;
        end else if (gap_q != 2'h0) begin
            int_ack <= 1'b0;
            gap_q   <= gap_q - 2'h1;
        end else if (accept_en && int_req
                     && int_level > {1'b0, cpu_threshold}) begin
            // Threshold field is never touched on acceptance
            int_ack <= 1'b1;
            gap_q   <= 2'h3;
        end
    end

endmodule : pic_cpu_model

// [verif/tb.sv]
// Self-checking testbench of the priority interrupt controller
`timescale 1ns/1ps

module tb;
    import pic_pkg::*;

    localparam int NP = 4;

    logic          clk_sys = 1'b0;
    logic          arst_n = 1'b0;
    logic [31:0]   reg_addr = '0, reg_wdata = '0, reg_rdata;
    logic          reg_wr = 1'b0, reg_rd = 1'b0;
    logic          nmi_pin = 1'b1, rtc_tick = 1'b0;
    logic [3:0]    irl_n = 4'hF, cpu_threshold = 4'h0;
    logic [NP-1:0] periph_req = '0;
    logic          cpu_hold = 1'b0, sleep_mode = 1'b0;
    logic          standby_mode = 1'b0, accept_en = 1'b0;
    logic          int_ack, int_req;
    logic [4:0]    int_level;
    logic [11:0]   int_code;
    int            bad_count = 0;
    int            comparisons = 0;

    always #4 clk_sys = ~clk_sys;

    pic_top #(.NPER(NP)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
        .irl_n(irl_n), .rtc_tick(rtc_tick), .periph_req(periph_req),
        .cpu_hold(cpu_hold), .cpu_threshold(cpu_threshold),
        .sleep_mode(sleep_mode), .standby_mode(standby_mode),
        .int_ack(int_ack), .int_req(int_req), .int_level(int_level),
        .int_code(int_code));

    pic_cpu_model cpu (.clk_sys(clk_sys), .arst_n(arst_n),
        .int_req(int_req), .int_level(int_level),
        .cpu_threshold(cpu_threshold), .accept_en(accept_en),
        .int_ack(int_ack));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [31:0] a,
                          input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask : rd_chk

    // Bounded wait for a presented request, then its level and code
    task automatic req_chk(input logic [4:0] lvl, input logic [11:0] code);
        int n;
        for (n = 0; n < 20 && int_req !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("int_req", int_req, 1'b1);
        chk("int_level", int_level, lvl);
        chk("int_code", int_code, code);
    endtask : req_chk

    task automatic take(input logic [11:0] code);
        int n;
        accept_en <= 1'b1;
        for (n = 0; n < 20 && int_ack !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        accept_en <= 1'b0;
        chk("int_ack", int_ack, 1'b1);
        cyc(3);
        rd_chk("event code", PIC_OFF_EVT, code);
    endtask : take

    task automatic idle_chk(input int n);
        cyc(n);
        #1;
        chk("int_req idle", int_req, 1'b0);
    endtask : idle_chk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk("ictrl", PIC_OFF_ICTRL, 32'h0000_8000);
        rd_chk("pri_a", PIC_OFF_PRI_A, 32'h0000_0000);
        rd_chk("pri_d", PIC_OFF_PRI_D, 32'h0000_DA74);
        rd_chk("pri00", PIC_OFF_PRI00, 32'h0000_0000);
        rd_chk("mask00", PIC_OFF_MASK00, 32'h0000_03FF);
        rd_chk("pend00", PIC_OFF_PEND00, 32'h0000_0000);
        rd_chk("unmapped", 32'hFFD0_0040, 32'h0000_0000);
    endtask : t_reset

    task automatic t_nmi;
        // Select rising first, so the falling pin below is not a request
        wr(PIC_OFF_ICTRL, 32'h0000_0100);
        cyc(7);
        nmi_pin <= 1'b0;
        rd_chk("pin low", PIC_OFF_ICTRL, 32'h0000_0100);
        idle_chk(2);
        nmi_pin <= 1'b1;
        req_chk(5'h10, 12'h1C0);
        take(12'h1C0);
        cpu_hold <= 1'b1;
        nmi_pin  <= 1'b0;
        cyc(2);
        nmi_pin <= 1'b1;
        idle_chk(6);
        wr(PIC_OFF_ICTRL, 32'h0000_0300);
        req_chk(5'h10, 12'h1C0);
        take(12'h1C0);
        wr(PIC_OFF_ICTRL, 32'h0000_0100);
        sleep_mode <= 1'b1;
        nmi_pin    <= 1'b0;
        cyc(2);
        nmi_pin <= 1'b1;
        req_chk(5'h10, 12'h1C0);
        take(12'h1C0);
        sleep_mode <= 1'b0;
        cpu_hold   <= 1'b0;
        // Falling edge inside the blind window after a polarity change
        nmi_pin    <= 1'b0;
        cyc(2);
        wr(PIC_OFF_ICTRL, 32'h0000_0000);
        nmi_pin <= 1'b1;
        cyc(1);
        nmi_pin <= 1'b0;
        idle_chk(6);
    endtask : t_nmi

    task automatic t_irl;
        irl_n <= 4'h5;
        cyc(2);
        irl_n <= 4'hF;
        idle_chk(6);
        irl_n <= 4'h5;
        req_chk(5'h0A, 12'h2A0);
        cpu_threshold <= 4'hA;
        idle_chk(3);
        cpu_threshold <= 4'h9;
        take(12'h2A0);
        // Level is lowered only once handling has begun
        irl_n         <= 4'hF;
        cpu_threshold <= 4'h0;
        idle_chk(6);
    endtask : t_irl

    task automatic t_periph;
        // Software edits flags only under hold, then reads back
        cpu_hold <= 1'b1;
        wr(PIC_OFF_PRI_A, 32'h0000_0055);
        wr(PIC_OFF_MCLR00, 32'h0000_0011);
        rd_chk("mask00 clr", PIC_OFF_MASK00, 32'h0000_03EE);
        wr(PIC_OFF_MASK00, 32'h0000_0001);
        rd_chk("mask00 set", PIC_OFF_MASK00, 32'h0000_03EF);
        rd_chk("pri_a rw", PIC_OFF_PRI_A, 32'h0000_0055);
        cpu_hold <= 1'b0;
        periph_req <= 4'b0100;
        idle_chk(4);
        periph_req <= 4'b0110;
        req_chk(5'h05, 12'h420);
        periph_req <= 4'b0111;
        cyc(2);
        req_chk(5'h05, 12'h400);
        take(12'h400);
        periph_req <= '0;
        idle_chk(3);
    endtask : t_periph

    task automatic t_indep;
        wr(PIC_OFF_ICTRL, 32'h0000_0180);
        irl_n <= 4'b1110;
        req_chk(5'h0D, 12'h240);
        irl_n <= 4'hF;
        idle_chk(4);
        wr(PIC_OFF_ICTRL, 32'h0000_0100);
        idle_chk(6);
    endtask : t_indep

    task automatic t_standby;
        standby_mode <= 1'b1;
        irl_n        <= 4'h0;
        idle_chk(8);
        repeat (4) begin
            rtc_tick <= 1'b1;
            cyc(1);
            rtc_tick <= 1'b0;
            cyc(3);
        end
        req_chk(5'h0F, 12'h200);
    endtask : t_standby

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Whole run takes well under a thousand cycles
    initial begin
        #100000;
        bad_count++;
        final_report();
    end

    initial begin
        cyc(2);
        arst_n <= 1'b1;
        t_reset();
        t_nmi();
        t_irl();
        t_periph();
        t_indep();
        t_standby();
        final_report();
    end

endmodule : tb
